// ---- hdl/lsbv_chain.sv ----
// Certificate chain walker: key-hash compare, signature check, hash hand-on.
// Assumes an outside hash and RSA engine answer certReq and sigReq.
`timescale 1ns/1ps
module lsbv_chain (
  input  wire logic  core_clk,
  input  wire logic  srst,
  lsbv_chain_if.eng  ch
);
  import lsbv_pkg::*;

  typedef enum logic [5:0] {
    C_IDLE = 6'h01,
    C_HASH = 6'h02,
    C_SIG  = 6'h04,
    C_PASS = 6'h08,
    C_FAIL = 6'h10,
    C_HOLD = 6'h20
  } lsbv_cst_e;

  lsbv_cst_e         state;
  logic [HASH_W-1:0] expHash;            // Hash the next certificate key must match
  logic [1:0]        idx;
  logic              certReq;
  logic              sigReq;

  // Decodes of the current step
  wire hashMatch = (ch.keyHash == expHash);
  wire lastCert  = (idx == ch.chainLen - 2'h1);
  wire lenOk     = (ch.chainLen == CHAIN_LEN_MIN) || (ch.chainLen == CHAIN_LEN_MAX);

  assign ch.certReq = certReq;
  assign ch.sigReq  = sigReq;
  assign ch.certIdx = idx;
  assign ch.done    = (state == C_PASS) || (state == C_FAIL);
  assign ch.pass    = (state == C_PASS);

  // Walk one certificate at a time; any mismatch ends in C_FAIL
  always_ff @(posedge core_clk) begin
    certReq <= 1'b0;
    sigReq  <= 1'b0;
    if (srst) begin
      state  <= C_IDLE;
      expHash <= '0;
      idx    <= 2'h0;
    end else begin
      case (state)
        C_IDLE, C_HOLD: if (ch.start) begin
          idx <= 2'h0;
          expHash <= ch.rootHash;
          if (lenOk) begin
            certReq <= 1'b1;
            state   <= C_HASH;
          end else state <= C_FAIL;
        end
        C_HASH: if (ch.keyHashValid) begin
          if (hashMatch) begin
            sigReq <= 1'b1;
            state  <= C_SIG;
          end else state <= C_FAIL;
        end
        C_SIG: if (ch.sigDone) begin
          if (!ch.sigOk) state <= C_FAIL;
          else if (lastCert) state <= C_PASS;
          else begin
            expHash <= ch.nextHash;
            idx     <= idx + 2'h1;
            certReq <= 1'b1;
            state   <= C_HASH;
          end
        end
        C_PASS, C_FAIL: state <= C_HOLD; // Result stands one cycle
        default: state <= C_IDLE;
      endcase
    end
  end

  // First certificate is checked against the root, later ones against the saved hash
  a_first_root: assert property (@(posedge core_clk) disable iff (srst)
    (state inside {C_IDLE, C_HOLD}) && ch.start && lenOk |=> expHash == $past(ch.rootHash))
    else $error("first expected hash is not the root");
  // Passing a non-last certificate stores its next hash
  a_save_next: assert property (@(posedge core_clk) disable iff (srst)
    state == C_SIG && ch.sigDone && ch.sigOk && !lastCert |=> expHash == $past(ch.nextHash))
    else $error("next hash not saved");
  // Signature check only follows a matching key hash
  a_sig_after: assert property (@(posedge core_clk) disable iff (srst)
    sigReq |-> $past(state == C_HASH && ch.keyHashValid && hashMatch))
    else $error("signature check without hash match");
  // A mismatch always ends the walk as failed
  a_fail_hash: assert property (@(posedge core_clk) disable iff (srst)
    state == C_HASH && ch.keyHashValid && !hashMatch |=> ch.done && !ch.pass)
    else $error("hash mismatch not failed");
endmodule : lsbv_chain

// ---- hdl/lsbv_chain_if.sv ----
// Carrier between the boot sequencer and the certificate chain walker.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
interface lsbv_chain_if;
  import lsbv_pkg::*;
  logic              start;
  logic [HASH_W-1:0] rootHash;
  logic [1:0]        chainLen;
  logic              done;
  logic              pass;
  logic              certReq;
  logic [1:0]        certIdx;
  logic [HASH_W-1:0] keyHash;
  logic              keyHashValid;
  logic [HASH_W-1:0] nextHash;
  logic              sigReq;
  logic              sigDone;
  logic              sigOk;
  modport mgr (output start, rootHash, chainLen, keyHash, keyHashValid, nextHash, sigDone, sigOk,
               input done, pass, certReq, certIdx, sigReq);
  modport eng (input start, rootHash, chainLen, keyHash, keyHashValid, nextHash, sigDone, sigOk,
               output done, pass, certReq, certIdx, sigReq);
endinterface : lsbv_chain_if

// ---- hdl/lsbv_pkg.sv ----
// Constants shared by the lifecycle decoder and the certificate chain walker.
// Assumes a word-addressed fuse memory with 32-bit words.
package lsbv_pkg;
  localparam int          FUSE_AW          = 11;
  localparam int          HASH_W           = 128;
  localparam int          HASH_WORDS       = 4;
  localparam int          ADDR_W           = 32;
  localparam int          RSA_KEY_BITS     = 3072;   // Modulus size of the signature engine
  // Fuse word addresses
  localparam logic [10:0] FUSE_CM_FLAGS    = 11'h010;
  localparam logic [10:0] FUSE_DM_FLAGS    = 11'h021;
  localparam logic [10:0] FUSE_CM_ROOT     = 11'h011;  // Four words, 0x11-0x14
  localparam logic [10:0] FUSE_DM_ROOT     = 11'h015;  // Four words, 0x15-0x18
  // Device-maker flag word fields
  localparam int          DM_ZCNT_LSB      = 0;
  localparam int          DM_ZCNT_MSB      = 7;
  localparam int          DM_RA_FLAG_BIT   = 30;
  localparam int          CM_RA_FLAG_BIT   = 31;
  // Chain and component limits
  localparam logic [1:0]  CHAIN_LEN_MIN    = 2'h2;
  localparam logic [1:0]  CHAIN_LEN_MAX    = 2'h3;
  localparam logic [1:0]  MAX_COMPONENTS   = 2'h3;
  // Lifecycle state codes
  typedef enum logic [1:0] {
    LCS_CHIP_MAKER   = 2'h0,
    LCS_DEVICE_MAKER = 2'h1,
    LCS_DEPLOYED     = 2'h2,
    LCS_RETURN       = 2'h3
  } lsbv_lcs_e;
endpackage : lsbv_pkg

// ---- hdl/lsbv_top.sv ----
// Lifecycle decode, debug and key gating, and authenticated boot sequencing.
// Assumes a fuse controller and crypto engine on core_clk with valid strobes.
`timescale 1ns/1ps

// What this block does
// - Flags 0x10 nonzero and 0x21 bits [7:0] zero decode device-maker state.
// - Flags 0x10 nonzero and 0x21 bits [7:0] nonzero decode deployed state.
// - Device-maker state keeps serial and scan debug ports enabled.
// - Deployed state blocks debug unless the image holds a verified debug certificate.
// - Deployed state always verifies the chain before loading anything.
// - Programmer writes device root hash and count; next power-on moves to deployed.
// - Return-analysis state replaces the unique key with fresh randomness each boot.
// - Return-analysis state invalidates both code-encryption keys.
// - Return-analysis state invalidates both provisioning keys.
// - Return-analysis state is terminal, debug open, crypto for test only.
// - Return-analysis entry needs both chip-maker and device-maker certificate flags.
// - Key hash compares with fuse root first, then with the saved hash.
// - Signature check with the certificate key follows the hash check.
// - Passing certificate hands its next hash on, except the last.
// - Chains of two or three certificates, walked in order.
// - Content certificate loops over load, storage address and size, three at most.
// - Both flag words zero is chip-maker state with all debug enabled.
module lsbv_top (
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  // Fuse memory read port
  output logic [lsbv_pkg::FUSE_AW-1:0]   fuseAddr,
  output logic                           fuseRdEn,
  input  wire logic                      fuseRdValid,
  input  wire logic [31:0]               fuseRdData,
  // Image facts from the boot image loader
  input  wire logic [1:0]                imgChainLen,
  input  wire logic                      dbgCertOk,
  // Certificate engine
  output logic                           certReq,
  output logic [1:0]                     certIdx,
  input  wire logic [lsbv_pkg::HASH_W-1:0] keyHash,
  input  wire logic                      keyHashValid,
  input  wire logic [lsbv_pkg::HASH_W-1:0] nextHash,
  output logic                           sigReq,
  input  wire logic                      sigDone,
  input  wire logic                      sigOk,
  // Component table from the content certificate
  output logic                           compReq,
  output logic [1:0]                     compIdx,
  input  wire logic                      compValid,
  input  wire logic [1:0]                compCount,
  input  wire logic [lsbv_pkg::ADDR_W-1:0] compLoadAddr,
  input  wire logic [lsbv_pkg::ADDR_W-1:0] compStoreAddr,
  input  wire logic [lsbv_pkg::ADDR_W-1:0] compSize,
  // Component copy engine
  output logic                           loadReq,
  output logic [lsbv_pkg::ADDR_W-1:0]    loadAddr,
  output logic [lsbv_pkg::ADDR_W-1:0]    storeAddr,
  output logic [lsbv_pkg::ADDR_W-1:0]    loadSize,
  input  wire logic                      loadDone,
  // Lifecycle results
  output lsbv_pkg::lsbv_lcs_e            lifecycleState,
  output logic                           lcsValid,
  output logic                           serialDbgEn,
  output logic                           scanDbgEn,
  output logic                           hukUseRandom,
  output logic                           rngReq,
  output logic                           codeKeysValid,
  output logic                           provKeysValid,
  output logic                           cryptoTestOnly,
  output logic                           bootGo,
  output logic                           bootAbort
);
  import lsbv_pkg::*;

  typedef enum logic [8:0] {
    T_RD10   = 9'h001,
    T_RD21   = 9'h002,
    T_RDROOT = 9'h004,
    T_DECIDE = 9'h008,
    T_VERIFY = 9'h010,
    T_COMP   = 9'h020,
    T_LOAD   = 9'h040,
    T_RUN    = 9'h080,
    T_ABORT  = 9'h100
  } lsbv_tst_e;

  lsbv_tst_e         state;
  logic [31:0]       cmFlags;
  logic [31:0]       dmFlags;
  logic [HASH_W-1:0] rootHash;
  logic [1:0]        rootCnt;
  logic              chainStart;
  logic              chainPassed;
  logic [1:0]        compTotal;

  lsbv_chain_if chIf ();

  lsbv_chain u_chain (
    .core_clk (core_clk),
    .srst     (srst),
    .ch       (chIf.eng)
  );

  // Engine traffic rides the carrier; requests come from the walker's flops
  assign chIf.start        = chainStart;
  assign chIf.rootHash     = rootHash;
  assign chIf.chainLen     = imgChainLen;
  assign chIf.keyHash      = keyHash;
  assign chIf.keyHashValid = keyHashValid;
  assign chIf.nextHash     = nextHash;
  assign chIf.sigDone      = sigDone;
  assign chIf.sigOk        = sigOk;
  assign certReq           = chIf.certReq;
  assign certIdx           = chIf.certIdx;
  assign sigReq            = chIf.sigReq;

  // Lifecycle decode from the two flag words
  function automatic lsbv_lcs_e decodeLcs(input logic [31:0] cm, input logic [31:0] dm);
    if (dm[CM_RA_FLAG_BIT] && dm[DM_RA_FLAG_BIT]) decodeLcs = LCS_RETURN;
    else if (cm == 32'h0000_0000) decodeLcs = LCS_CHIP_MAKER;
    else if (dm[DM_ZCNT_MSB:DM_ZCNT_LSB] == 8'h00) decodeLcs = LCS_DEVICE_MAKER;
    else decodeLcs = LCS_DEPLOYED;
  endfunction : decodeLcs

  // Decode and gating as named wires
  wire lsbv_lcs_e next_lcs   = decodeLcs(cmFlags, dmFlags);
  wire            isReturn   = (next_lcs == LCS_RETURN);
  wire            isDeployed = (next_lcs == LCS_DEPLOYED);
  wire            needVerify = isDeployed || isReturn;
  wire            rootIsChip = isReturn && (dmFlags[DM_ZCNT_MSB:DM_ZCNT_LSB] == 8'h00);
  // Debug: open outside deployed, in deployed only with a verified debug certificate
  wire            next_dbg   = !isDeployed || dbgCertOk;
  wire [1:0]      compLimit  = (compTotal > MAX_COMPONENTS) ? MAX_COMPONENTS : compTotal;
  wire            compLast   = (compIdx + 2'h1 >= compLimit);
  wire            lastRoot   = (rootCnt == 2'(HASH_WORDS - 1));
  wire [FUSE_AW-1:0] rootBase = rootIsChip ? FUSE_CM_ROOT : FUSE_DM_ROOT;

  // Boot sequencer: fuse reads, decode, chain, component loop
  always_ff @(posedge core_clk) begin
    fuseRdEn   <= 1'b0;
    chainStart <= 1'b0;
    compReq    <= 1'b0;
    loadReq    <= 1'b0;
    rngReq     <= 1'b0;
    if (srst) begin
      state       <= T_RD10;
      fuseAddr    <= FUSE_CM_FLAGS;
      fuseRdEn    <= 1'b1;
      cmFlags     <= 32'h0000_0000;
      dmFlags     <= 32'h0000_0000;
      rootHash    <= '0;
      rootCnt     <= 2'h0;
      chainPassed <= 1'b0;
      compIdx     <= 2'h0;
      compTotal   <= 2'h0;
      loadAddr    <= '0;
      storeAddr   <= '0;
      loadSize    <= '0;
      bootGo      <= 1'b0;
      bootAbort   <= 1'b0;
    end else begin
      case (state)
        T_RD10: if (fuseRdValid) begin
          cmFlags  <= fuseRdData;
          fuseAddr <= FUSE_DM_FLAGS;
          fuseRdEn <= 1'b1;
          state    <= T_RD21;
        end
        T_RD21: if (fuseRdValid) begin
          dmFlags <= fuseRdData;
          state   <= T_DECIDE;
        end
        T_DECIDE: begin
          // State is taken once per reset; a fresh power-on re-decodes it
          rngReq <= isReturn;
          if (needVerify) begin
            fuseAddr <= rootBase;
            fuseRdEn <= 1'b1;
            rootCnt  <= 2'h0;
            state    <= T_RDROOT;
          end else begin
            bootGo <= 1'b1;
            state  <= T_RUN;
          end
        end
        T_RDROOT: if (fuseRdValid) begin
          rootHash <= {fuseRdData, rootHash[HASH_W-1:32]};
          if (lastRoot) begin
            chainStart <= 1'b1;
            state      <= T_VERIFY;
          end else begin
            rootCnt  <= rootCnt + 2'h1;
            fuseAddr <= fuseAddr + 11'h001;
            fuseRdEn <= 1'b1;
          end
        end
        T_VERIFY: if (chIf.done) begin
          if (chIf.pass) begin
            chainPassed <= 1'b1;
            compIdx     <= 2'h0;
            compReq     <= 1'b1;
            state       <= T_COMP;
          end else begin
            bootAbort <= 1'b1;
            state     <= T_ABORT;
          end
        end
        T_COMP: if (compValid) begin
          compTotal <= compCount;
          if (compCount == 2'h0) begin
            bootGo <= 1'b1;
            state  <= T_RUN;
          end else begin
            loadAddr  <= compLoadAddr;
            storeAddr <= compStoreAddr;
            loadSize  <= compSize;
            loadReq   <= 1'b1;
            state     <= T_LOAD;
          end
        end
        T_LOAD: if (loadDone) begin
          if (compLast) begin
            bootGo <= 1'b1;
            state  <= T_RUN;
          end else begin
            compIdx <= compIdx + 2'h1;
            compReq <= 1'b1;
            state   <= T_COMP;
          end
        end
        T_RUN, T_ABORT: state <= state; // Held until the next reset
        default: state <= T_ABORT;
      endcase
    end
  end

  // Lifecycle outputs: everything closed until decode, then set once; deployed debug then follows dbgCertOk
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lifecycleState <= LCS_CHIP_MAKER;
      lcsValid       <= 1'b0;
      serialDbgEn    <= 1'b0;
      scanDbgEn      <= 1'b0;
      hukUseRandom   <= 1'b0;
      codeKeysValid  <= 1'b0;
      provKeysValid  <= 1'b0;
      cryptoTestOnly <= 1'b0;
    end else if (state == T_DECIDE) begin
      lifecycleState <= next_lcs;
      lcsValid       <= 1'b1;
      hukUseRandom   <= isReturn;
      codeKeysValid  <= !isReturn;
      provKeysValid  <= !isReturn;
      cryptoTestOnly <= isReturn;
      serialDbgEn    <= next_dbg;
      scanDbgEn      <= next_dbg;
    end else if (lcsValid && lifecycleState == LCS_DEPLOYED) begin
      // Late debug certificate result still opens the ports
      serialDbgEn <= dbgCertOk;
      scanDbgEn   <= dbgCertOk;
    end
  end

  sequence s_verified;
    chainPassed;
  endsequence

  // Loads in secured states only after a passing chain
  a_load_verified: assert property (@(posedge core_clk) disable iff (srst)
    loadReq && lifecycleState inside {LCS_DEPLOYED, LCS_RETURN} |-> s_verified)
    else $error("component load without verified chain");
  // No load once aborted
  a_abort_noload: assert property (@(posedge core_clk) disable iff (srst)
    bootAbort |-> !loadReq && !bootGo)
    else $error("load or run after abort");
  // Device-maker state decode and open debug
  a_dm_decode: assert property (@(posedge core_clk) disable iff (srst)
    state == T_DECIDE && cmFlags != 32'h0 && dmFlags[7:0] == 8'h00 && !isReturn
    |=> lifecycleState == LCS_DEVICE_MAKER && serialDbgEn && scanDbgEn)
    else $error("device-maker decode or debug wrong");
  a_dep_decode: assert property (@(posedge core_clk) disable iff (srst)
    state == T_DECIDE && cmFlags != 32'h0 && dmFlags[7:0] != 8'h00 && !isReturn
    |=> lifecycleState == LCS_DEPLOYED)
    else $error("deployed decode wrong");
  a_dep_dbg: assert property (@(posedge core_clk) disable iff (srst)
    lcsValid && lifecycleState == LCS_DEPLOYED && !$past(dbgCertOk) |-> !serialDbgEn)
    else $error("debug open in deployed state");
  a_chip_default: assert property (@(posedge core_clk) disable iff (srst)
    state == T_DECIDE && cmFlags == 32'h0 && dmFlags == 32'h0
    |=> lifecycleState == LCS_CHIP_MAKER ##0 serialDbgEn && scanDbgEn)
    else $error("chip-maker default wrong");
  a_ra_keys: assert property (@(posedge core_clk) disable iff (srst)
    lcsValid && lifecycleState == LCS_RETURN
    |-> hukUseRandom && !codeKeysValid && !provKeysValid && serialDbgEn && cryptoTestOnly)
    else $error("return-analysis key handling wrong");
  a_comp_limit: assert property (@(posedge core_clk) disable iff (srst)
    loadReq |-> compIdx < MAX_COMPONENTS)
    else $error("more than three components");
endmodule : lsbv_top

// ---- verification/lsbv_far_model.sv ----
// Far-side model: fuse memory, hash and signature engine, component table, copy engine.
// Assumes the design launches requests on the rising edge; answers land at the falling edge.
`timescale 1ns/1ps
module lsbv_far_model (
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  input  wire logic [lsbv_pkg::FUSE_AW-1:0] fuseAddr,
  input  wire logic                         fuseRdEn,
  output logic                              fuseRdValid,
  output logic [31:0]                       fuseRdData,
  input  wire logic                         certReq,
  input  wire logic [1:0]                   certIdx,
  output logic [lsbv_pkg::HASH_W-1:0]       keyHash,
  output logic                              keyHashValid,
  output logic [lsbv_pkg::HASH_W-1:0]       nextHash,
  input  wire logic                         sigReq,
  output logic                              sigDone,
  output logic                              sigOk,
  input  wire logic                         compReq,
  input  wire logic [1:0]                   compIdx,
  output logic                              compValid,
  output logic [1:0]                        compCount,
  output logic [lsbv_pkg::ADDR_W-1:0]       compLoadAddr,
  output logic [lsbv_pkg::ADDR_W-1:0]       compStoreAddr,
  output logic [lsbv_pkg::ADDR_W-1:0]       compSize,
  input  wire logic                         loadReq,
  input  wire logic [lsbv_pkg::ADDR_W-1:0]  loadAddr,
  input  wire logic [lsbv_pkg::ADDR_W-1:0]  storeAddr,
  input  wire logic [lsbv_pkg::ADDR_W-1:0]  loadSize,
  output logic                              loadDone,
  input  wire logic                         rngReq,
  input  wire logic [31:0]                  cfgW10,
  input  wire logic [31:0]                  cfgW21,
  input  wire logic [1:0]                   cfgNcomp,
  input  wire logic [1:0]                   cfgBadHash,
  input  wire logic [1:0]                   cfgBadSig,
  output logic [31:0]                       certCnt,
  output logic [31:0]                       loadCnt,
  output logic [31:0]                       loadErr,
  output logic [31:0]                       rngCnt
);
  import lsbv_pkg::*;
  localparam logic [HASH_W-1:0] ROOT = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  logic [1:0]  curIdx;
  logic [1:0]  lastComp;
  logic [31:0] fuseWord;
  // Both root areas hold the same hash, word 0 carries bits [31:0]
  assign fuseWord = (fuseAddr == FUSE_CM_FLAGS) ? cfgW10 :
                    (fuseAddr == FUSE_DM_FLAGS) ? cfgW21 :
                    (fuseAddr >= FUSE_CM_ROOT && fuseAddr <= 11'h018) ?
                    ROOT[32*((fuseAddr-11'h001) & 11'h003) +: 32] : {21'h0, ~fuseAddr};
  initial begin
    {fuseRdValid, keyHashValid, sigDone, sigOk, compValid, loadDone} = 6'h00;
    {fuseRdData, keyHash, nextHash, compCount} = '0;
    {compLoadAddr, compStoreAddr, compSize} = '0;
  end
  // One-cycle answers; released fuse and hash data lines toggle so nothing stale reads as valid
  always @(negedge core_clk) begin
    {fuseRdValid, keyHashValid, sigDone, compValid, loadDone} <= 5'h00;
    fuseRdData <= ~fuseRdData;
    keyHash    <= ~keyHash;
    nextHash   <= ~nextHash;
    // The first flag read is launched while reset still stands
    if (fuseRdEn) begin
      fuseRdValid <= 1'b1;
      fuseRdData  <= fuseWord;
    end
    if (srst) begin
      {certCnt, loadCnt, loadErr, rngCnt} <= '0;
    end else begin
      if (certReq) begin
        curIdx       <= certIdx;
        certCnt      <= certCnt + 1;
        keyHashValid <= 1'b1;
        keyHash      <= ((certIdx == 2'h0) ? ROOT : ROOT ^ certIdx) ^ (certIdx == cfgBadHash);
      end
      if (sigReq) begin
        sigDone  <= 1'b1;
        sigOk    <= (curIdx != cfgBadSig);
        nextHash <= ROOT ^ (curIdx + 2'h1);
      end
      if (compReq) begin
        lastComp      <= compIdx;
        compValid     <= 1'b1;
        compCount     <= cfgNcomp;
        compLoadAddr  <= 32'h2000_0000 | compIdx;
        compStoreAddr <= 32'h0010_0000 | compIdx;
        compSize      <= 32'h0000_0400 + compIdx;
      end
      if (loadReq) begin
        loadDone <= 1'b1;
        loadCnt  <= loadCnt + 1;
        if (loadAddr !== (32'h2000_0000 | lastComp) || storeAddr !== (32'h0010_0000 | lastComp) ||
            loadSize !== (32'h0000_0400 + lastComp))
          loadErr <= loadErr + 1;
      end
      if (rngReq)
        rngCnt <= rngCnt + 1;
    end
  end
endmodule : lsbv_far_model

// ---- verification/tb.sv ----
// Self-checking bench: boots the lifecycle block under a series of fuse and image setups.
// Assumes the far-side model answers every request within a few cycles.
`timescale 1ns/1ps
module tb;
  import lsbv_pkg::*;
  logic                core_clk, srst, fuseRdEn, fuseRdValid, keyHashValid, sigDone, sigOk;
  logic [FUSE_AW-1:0]  fuseAddr;
  logic [31:0]         fuseRdData, cfgW10, cfgW21, certCnt, loadCnt, loadErr, rngCnt;
  logic [1:0]          imgChainLen, certIdx, compIdx, compCount, cfgNcomp, cfgBadHash, cfgBadSig;
  logic                dbgCertOk, certReq, sigReq, compReq, compValid, loadReq, loadDone;
  logic [HASH_W-1:0]   keyHash, nextHash;
  logic [ADDR_W-1:0]   compLoadAddr, compStoreAddr, compSize, loadAddr, storeAddr, loadSize;
  lsbv_lcs_e           lifecycleState;
  logic                lcsValid, serialDbgEn, scanDbgEn, hukUseRandom, rngReq, codeKeysValid;
  logic                provKeysValid, cryptoTestOnly, bootGo, bootAbort;
  int                  errors, num_checks;

  lsbv_top dut (.*);
  lsbv_far_model partner (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    {srst, dbgCertOk, imgChainLen, cfgW10, cfgW21} = '1;
    {cfgNcomp, cfgBadHash, cfgBadSig} = 6'h3F;
    errors = 0;
    num_checks = 0;
  end

  task automatic end_sim();
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] expv, input logic [31:0] got);
    num_checks++;
    if (got !== expv) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, expv, got);
    end
  endtask : chk

  // Fresh power-on with given fuse words and image, then wait for a boot verdict
  task automatic boot(input logic [31:0] w10, input logic [31:0] w21, input logic [1:0] len,
                      input logic [1:0] nc, input logic [1:0] badH, input logic [1:0] badS,
                      input logic dbg);
    int n;
    @(negedge core_clk);
    srst = 1'b1;
    {cfgW10, cfgW21, imgChainLen, cfgNcomp, cfgBadHash, cfgBadSig, dbgCertOk} =
      {w10, w21, len, nc, badH, badS, dbg};
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    n = 0;
    while (bootGo !== 1'b1 && bootAbort !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    repeat (3) @(negedge core_clk);  // Debug gates are registered
    chk("boot verdict in time", 32'h1, n < 400);
  endtask : boot

  task automatic expect_boot(input logic [1:0] st, input logic dbgOn, input logic [1:0] certs,
                             input logic [1:0] loads, input logic go);
    chk("lifecycleState", st, lifecycleState);
    chk("lcsValid", 1'b1, lcsValid);
    chk("serialDbgEn", dbgOn, serialDbgEn);
    chk("scanDbgEn", dbgOn, scanDbgEn);
    chk("certReq count", certs, certCnt);
    chk("loadReq count", loads, loadCnt);
    chk("load fields", 32'h0, loadErr);
    chk("bootGo", go, bootGo);
    chk("bootAbort", !go, bootAbort);
  endtask : expect_boot

  task automatic expect_keys(input logic ra);
    chk("hukUseRandom", ra, hukUseRandom);
    chk("rngReq seen", ra, rngCnt != 0);
    chk("codeKeysValid", !ra, codeKeysValid);
    chk("provKeysValid", !ra, provKeysValid);
    chk("cryptoTestOnly", ra, cryptoTestOnly);
  endtask : expect_keys

  // Boot scenarios: none means a bad index of 3
  initial begin
    boot(32'h0, 32'h0, 2'h3, 2'h3, 2'h3, 2'h3, 1'b0);
    expect_boot(LCS_CHIP_MAKER, 1'b1, 2'h0, 2'h0, 1'b1);
    boot(32'h1, 32'h0, 2'h3, 2'h3, 2'h3, 2'h3, 1'b0);
    expect_boot(LCS_DEVICE_MAKER, 1'b1, 2'h0, 2'h0, 1'b1);
    boot(32'h1, 32'h0000_0055, 2'h3, 2'h3, 2'h3, 2'h3, 1'b0);
    expect_boot(LCS_DEPLOYED, 1'b0, 2'h3, 2'h3, 1'b1);
    expect_keys(1'b0);
    boot(32'h1, 32'h0000_0055, 2'h2, 2'h0, 2'h3, 2'h3, 1'b1);
    expect_boot(LCS_DEPLOYED, 1'b1, 2'h2, 2'h0, 1'b1);
    boot(32'h1, 32'h0000_0055, 2'h3, 2'h2, 2'h1, 2'h3, 1'b0);
    expect_boot(LCS_DEPLOYED, 1'b0, 2'h2, 2'h0, 1'b0);
    boot(32'h1, 32'h0000_0055, 2'h2, 2'h1, 2'h0, 2'h3, 1'b0);
    expect_boot(LCS_DEPLOYED, 1'b0, 2'h1, 2'h0, 1'b0);
    boot(32'h1, 32'h0000_0055, 2'h3, 2'h1, 2'h3, 2'h2, 1'b0);
    expect_boot(LCS_DEPLOYED, 1'b0, 2'h3, 2'h0, 1'b0);
    boot(32'h1, 32'h0000_0055, 2'h1, 2'h1, 2'h3, 2'h3, 1'b0);
    expect_boot(LCS_DEPLOYED, 1'b0, 2'h0, 2'h0, 1'b0);
    boot(32'h1, 32'hC000_0000, 2'h2, 2'h1, 2'h3, 2'h3, 1'b0);
    expect_boot(LCS_RETURN, 1'b1, 2'h2, 2'h1, 1'b1);
    expect_keys(1'b1);
    boot(32'h1, 32'h8000_0055, 2'h2, 2'h1, 2'h3, 2'h3, 1'b0);
    expect_boot(LCS_DEPLOYED, 1'b0, 2'h2, 2'h1, 1'b1);
    boot(32'h1, 32'h4000_0000, 2'h2, 2'h1, 2'h3, 2'h3, 1'b0);
    expect_boot(LCS_DEVICE_MAKER, 1'b1, 2'h0, 2'h0, 1'b1);
    end_sim();
  end

  // Watchdog well past eleven boots of a few dozen cycles each
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_sim();
  end
endmodule : tb
